// [shared/fcs_cfg.svh]
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
// Operation codes of the compare unit
`define FCS_OPC_NEQFLAGS   8'h97
`define FCS_OPC_SIGN       8'h98
`define FCS_OPC_SIGNFLAGS  8'h99
`define FCS_ISSUE_SLOT     3'h3
`define FCS_LATENCY        1
// Flag bit positions in the result vector and status word
`define FCS_BIT_DBZ        0
`define FCS_BIT_INX        1
`define FCS_BIT_UNF        2
`define FCS_BIT_OVF        3
`define FCS_BIT_INV        4
`define FCS_BIT_IFZ        5
`define FCS_BIT_OFZ        6
`define FCS_FLAGS_W        7
`define FCS_FLAGS_RST      7'h00
`define FCS_RES_RST        32'h0000_0000
`define FCS_RES_MINUS_ONE  32'hFFFF_FFFF
`define FCS_RES_PLUS_ONE   32'h0000_0001
`endif

// [shared/fcs_pkg.sv]
package fcs_pkg;
  typedef logic [6:0] fcs_flags_t;
  typedef struct packed {
    logic       zero;
    logic       neg;
    logic       denorm;
    logic       nan;
    logic       snan;
  } fcs_class_t;
  typedef enum logic [1:0] {
    FCS_OP_NONE      = 2'h0,
    FCS_OP_NEQFLAGS  = 2'h1,
    FCS_OP_SIGN      = 2'h3,
    FCS_OP_SIGNFLAGS = 2'h2
  } fcs_op_t;
endpackage

// [shared/fcs_cls_if.sv]
`timescale 1ns/1ps
interface fcs_cls_if;
  logic [31:0]        operand;
  fcs_pkg::fcs_class_t cls;
  modport producer (input operand, output cls);
  modport consumer (output operand, input cls);
endinterface

// [design/fcs_classify.sv]
`timescale 1ns/1ps
module fcs_classify
  import fcs_pkg::*;
(
  fcs_cls_if.producer c
);
  logic [7:0]  exp_w;
  logic [22:0] man_w;
  assign exp_w = c.operand[30:23];
  assign man_w = c.operand[22:0];
  // Denormals count as zero after flush
  assign c.cls.denorm = (exp_w == 8'h00) && (man_w != 23'h000000);
  assign c.cls.zero   = (exp_w == 8'h00);
  assign c.cls.neg    = c.operand[31];
  assign c.cls.nan    = (exp_w == 8'hFF) && (man_w != 23'h000000);
  assign c.cls.snan   = c.cls.nan && !man_w[22];
endmodule

// [design/fcs_sticky.sv]
`timescale 1ns/1ps
module fcs_sticky
  import fcs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_sync_b,
  input  wire logic       clk_en,
  input  wire logic       set_en,
  input  wire fcs_flags_t set_flags,
  input  wire fcs_flags_t other_flags,
  input  wire logic       wr_en,
  input  wire fcs_flags_t wr_flags,
  output fcs_flags_t      flags_r
);
  `include "fcs_cfg.svh"
  typedef struct packed {
    fcs_flags_t flags;
  } fcs_sticky_st_t;
  fcs_sticky_st_t st_r;
  fcs_sticky_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (clk_en)
    begin
      // Explicit write replaces, then simultaneous sets OR in so none is lost
      if (wr_en)
        st_nxt.flags = wr_flags;
      st_nxt.flags = st_nxt.flags | other_flags | (set_en ? set_flags : `FCS_FLAGS_RST);
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      st_r <= '{flags: `FCS_FLAGS_RST};
    else
      st_r <= st_nxt;
  end

  assign flags_r = st_r.flags;

  property p_sticky_hold;
    @(posedge clock) disable iff (!rst_sync_b)
    !$past(wr_en) |-> ((flags_r & $past(flags_r)) == $past(flags_r));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("status flag cleared without a write");
endmodule

// [design/fcs_unit.sv]
`timescale 1ns/1ps
module fcs_unit
  import fcs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        issue_valid,
  input  wire logic [7:0]  issue_opcode,
  input  wire logic [2:0]  issue_slot,
  input  wire logic [6:0]  issue_dest,
  input  wire logic [31:0] first_source_register,
  input  wire logic [31:0] second_source_register,
  input  wire logic        guard_present,
  input  wire logic [31:0] guard_value,
  input  wire logic        status_wr_en,
  input  wire logic [6:0]  status_wr_flags,
  input  wire logic [6:0]  other_unit_flags,
  output logic             dest_wr_en,
  output logic [6:0]       dest_index,
  output logic [31:0]      dest_data,
  output logic             slot_error,
  output logic [6:0]       program_status_word
);
  `include "fcs_cfg.svh"

  typedef struct packed {
    logic        wr_en;
    logic [6:0]  idx;
    logic [31:0] data;
    logic        slot_err;
  } fcs_st_t;

  fcs_st_t    st_r;
  fcs_st_t    st_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_sync_b;
  fcs_op_t    op;
  logic       run;
  logic       do_op;
  fcs_flags_t op_flags;
  logic [31:0] op_result;
  logic       psw_set;
  fcs_flags_t psw_set_flags;
  fcs_flags_t psw_q;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_sync_b = rst_sync_r[1];

  fcs_cls_if cls_a ();
  fcs_cls_if cls_b ();
  assign cls_a.operand = first_source_register;
  assign cls_b.operand = second_source_register;
  fcs_classify u_cls_a (.c(cls_a));
  fcs_classify u_cls_b (.c(cls_b));

  function automatic fcs_op_t decode(input logic [7:0] opc);
    case (opc)
      `FCS_OPC_NEQFLAGS:  decode = FCS_OP_NEQFLAGS;
      `FCS_OPC_SIGN:      decode = FCS_OP_SIGN;
      `FCS_OPC_SIGNFLAGS: decode = FCS_OP_SIGNFLAGS;
      default:            decode = FCS_OP_NONE;
    endcase
  endfunction

  function automatic fcs_flags_t flag_bit(input int pos);
    flag_bit = fcs_flags_t'(7'h01 << pos);
  endfunction

  // Exceptions of sign test, shared by the sign test and its flags form
  function automatic fcs_flags_t sign_flags(input fcs_class_t c);
    sign_flags = `FCS_FLAGS_RST;
    if (c.denorm)
      sign_flags = sign_flags | flag_bit(`FCS_BIT_IFZ);
    if (c.nan)
      sign_flags = sign_flags | flag_bit(`FCS_BIT_INV);
  endfunction

  assign op = decode(issue_opcode);
  // Other slots are not wired to this unit; flag misuse instead of executing
  assign run = clk_en && issue_valid && (op != FCS_OP_NONE)
               && (issue_slot == `FCS_ISSUE_SLOT);
  assign do_op = run && (!guard_present || guard_value[0]);

  always_comb
  begin
    op_flags  = `FCS_FLAGS_RST;
    op_result = `FCS_RES_RST;
    case (op)
      FCS_OP_NEQFLAGS:
      begin
        // Quiet compare: only signalling NaN is invalid
        if (cls_a.cls.denorm || cls_b.cls.denorm)
          op_flags = op_flags | flag_bit(`FCS_BIT_IFZ);
        if (cls_a.cls.snan || cls_b.cls.snan)
          op_flags = op_flags | flag_bit(`FCS_BIT_INV);
        op_result = {25'h0000000, op_flags};
      end
      FCS_OP_SIGN:
      begin
        op_flags = sign_flags(cls_a.cls);
        if (cls_a.cls.zero || cls_a.cls.nan)
          op_result = `FCS_RES_RST;
        else if (cls_a.cls.neg)
          op_result = `FCS_RES_MINUS_ONE;
        else
          op_result = `FCS_RES_PLUS_ONE;
      end
      FCS_OP_SIGNFLAGS:
      begin
        op_flags  = sign_flags(cls_a.cls);
        op_result = {25'h0000000, op_flags};
      end
      default:
      begin
        op_flags  = `FCS_FLAGS_RST;
        op_result = `FCS_RES_RST;
      end
    endcase
  end

  // Only the sign test touches the status word
  assign psw_set       = do_op && (op == FCS_OP_SIGN);
  assign psw_set_flags = op_flags;

  fcs_sticky u_sticky (
    .clock       (clock),
    .rst_sync_b  (rst_sync_b),
    .clk_en      (clk_en),
    .set_en      (psw_set),
    .set_flags   (psw_set_flags),
    .other_flags (other_unit_flags),
    .wr_en       (status_wr_en),
    .wr_flags    (status_wr_flags),
    .flags_r     (psw_q)
  );

  always_comb
  begin
    st_nxt = st_r;
    if (clk_en)
    begin
      st_nxt.wr_en    = do_op;
      st_nxt.idx      = issue_dest;
      st_nxt.data     = do_op ? op_result : st_r.data;
      st_nxt.slot_err = issue_valid && (op != FCS_OP_NONE)
                        && (issue_slot != `FCS_ISSUE_SLOT);
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      st_r <= '{wr_en: 1'b0, idx: 7'h00, data: `FCS_RES_RST, slot_err: 1'b0};
    else
      st_r <= st_nxt;
  end

  assign dest_wr_en          = st_r.wr_en;
  assign dest_index          = st_r.idx;
  assign dest_data           = st_r.data;
  assign slot_error          = st_r.slot_err;
  assign program_status_word = psw_q;

  property p_guard_blocks;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && guard_present && !guard_value[0]) |=> !dest_wr_en;
  endproperty
  a_guard_blocks: assert property (p_guard_blocks)
    else $error("write despite false guard");

  property p_unguarded_runs;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && !guard_present && issue_slot == 3'h3
     && issue_opcode inside {8'h97, 8'h98, 8'h99}) |=> dest_wr_en;
  endproperty
  a_unguarded_runs: assert property (p_unguarded_runs)
    else $error("unguarded op not written");

  property p_lat_one;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_slot == 3'h3 && !guard_present
     && issue_opcode == 8'h98 && first_source_register == 32'hBF800000)
    |=> dest_wr_en && dest_data == 32'hFFFFFFFF;
  endproperty
  a_lat_one: assert property (p_lat_one)
    else $error("negative sign wrong");

  property p_sign_pos;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_slot == 3'h3 && !guard_present
     && issue_opcode == 8'h98 && first_source_register == 32'h40400000)
    |=> dest_data == 32'h00000001;
  endproperty
  a_sign_pos: assert property (p_sign_pos)
    else $error("positive sign wrong");

  property p_denorm_sign;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_slot == 3'h3 && !guard_present
     && issue_opcode == 8'h98 && first_source_register == 32'h80400000)
    |=> dest_data == 32'h0 && program_status_word[5];
  endproperty
  a_denorm_sign: assert property (p_denorm_sign)
    else $error("denormal sign not flushed");

  property p_flags_hi_zero;
    @(posedge clock) disable iff (!rst_sync_b)
    ($past(clk_en && issue_valid && issue_opcode != 8'h98) && dest_wr_en)
    |-> dest_data[31:7] == 25'h0;
  endproperty
  a_flags_hi_zero: assert property (p_flags_hi_zero)
    else $error("flag vector upper bits set");

  property p_neq_ifz;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_slot == 3'h3 && !guard_present
     && issue_opcode == 8'h97 && first_source_register == 32'h3F800000
     && second_source_register == 32'h00400000) |=> dest_data == 32'h20;
  endproperty
  a_neq_ifz: assert property (p_neq_ifz)
    else $error("not-equal flush flag missing");

  property p_flags_psw_quiet;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_opcode inside {8'h97, 8'h99}
     && !status_wr_en && other_unit_flags == 7'h00)
    |=> program_status_word == $past(program_status_word);
  endproperty
  a_flags_psw_quiet: assert property (p_flags_psw_quiet)
    else $error("flags op changed status word");

  property p_guard_psw;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && guard_present && !guard_value[0]
     && !status_wr_en && other_unit_flags == 7'h00)
    |=> $stable(program_status_word);
  endproperty
  a_guard_psw: assert property (p_guard_psw)
    else $error("false guard changed status");

  property p_neq_snan;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_slot == 3'h3 && !guard_present
     && issue_opcode == 8'h97 && first_source_register == 32'h40400000
     && second_source_register == 32'h7FA00000) |=> dest_data == 32'h00000010;
  endproperty
  a_neq_snan: assert property (p_neq_snan)
    else $error("signalling compare not invalid");

  property p_neq_qnan;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_slot == 3'h3 && !guard_present
     && issue_opcode == 8'h97 && first_source_register == 32'h40400000
     && second_source_register == 32'hFFFFFFFF) |=> dest_data == 32'h00000000;
  endproperty
  a_neq_qnan: assert property (p_neq_qnan)
    else $error("quiet compare raised a flag");

  property p_sign_nan;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_slot == 3'h3 && (!guard_present || guard_value[0])
     && issue_opcode == 8'h98 && first_source_register == 32'hFFFFFFFF)
    |=> dest_wr_en && dest_data == 32'h00000000 && program_status_word[4];
  endproperty
  a_sign_nan: assert property (p_sign_nan)
    else $error("NaN sign result or status wrong");

  property p_signflags_denorm;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_slot == 3'h3 && !guard_present
     && issue_opcode == 8'h99 && first_source_register == 32'h80400000)
    |=> dest_data == 32'h00000020;
  endproperty
  a_signflags_denorm: assert property (p_signflags_denorm)
    else $error("sign flags flush bit missing");

  property p_slot_refused;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && issue_valid && issue_slot != 3'h3
     && issue_opcode inside {8'h97, 8'h98, 8'h99}) |=> !dest_wr_en && slot_error;
  endproperty
  a_slot_refused: assert property (p_slot_refused)
    else $error("wrong slot executed");

  property p_psw_or;
    @(posedge clock) disable iff (!rst_sync_b)
    clk_en |=> (program_status_word & $past(other_unit_flags)) == $past(other_unit_flags);
  endproperty
  a_psw_or: assert property (p_psw_or)
    else $error("simultaneous flag set lost");

  property p_write_clears;
    @(posedge clock) disable iff (!rst_sync_b)
    (clk_en && status_wr_en && !issue_valid && other_unit_flags == 7'h00)
    |=> program_status_word == $past(status_wr_flags);
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("status write not taken");
endmodule

// [tb/fcs_regfile_model.sv]
`timescale 1ns/1ps
module fcs_regfile_model (
  input wire logic        clock,
  input wire logic        wr_en,
  input wire logic [6:0]  wr_index,
  input wire logic [31:0] wr_data
);
  logic [31:0] regs [0:127];
  // Only a flagged write may touch the file
  always @(posedge clock)
  begin
    if (wr_en === 1'b1)
      regs[wr_index] <= wr_data;
  end
endmodule

// [tb/fcs_unit_tb.sv]
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_unit_tb;
  typedef struct {
    logic [7:0]  opc;
    logic [31:0] a;
    logic [31:0] b;
    logic [1:0]  g;
    logic        wr;
    logic [31:0] res;
    logic [6:0]  psw;
  } fcs_row_t;
  // Guard code: 0 absent, 2 false, 3 true
  fcs_row_t rows [0:17] = '{
    '{`FCS_OPC_NEQFLAGS, 32'h40400000, 32'h7FA00000, 2'h0, 1'b1, 32'h10, 7'h00},
    '{`FCS_OPC_NEQFLAGS, 32'h40400000, 32'hFFFFFFFF, 2'h0, 1'b1, 32'h0, 7'h00},
    '{`FCS_OPC_NEQFLAGS, 32'h40400000, 32'h0, 2'h0, 1'b1, 32'h0, 7'h00},
    '{`FCS_OPC_NEQFLAGS, 32'h3F800000, 32'h00400000, 2'h0, 1'b1, 32'h20, 7'h00},
    '{`FCS_OPC_NEQFLAGS, 32'h3F800000, 32'h40400000, 2'h2, 1'b0, 32'h20, 7'h00},
    '{`FCS_OPC_NEQFLAGS, 32'h3F800000, 32'h40400000, 2'h3, 1'b1, 32'h0, 7'h00},
    '{`FCS_OPC_SIGNFLAGS, 32'h80400000, 32'h0, 2'h0, 1'b1, 32'h20, 7'h00},
    '{`FCS_OPC_SIGNFLAGS, 32'hFFFFFFFF, 32'h0, 2'h3, 1'b1, 32'h10, 7'h00},
    '{`FCS_OPC_SIGNFLAGS, 32'hFF800000, 32'h0, 2'h0, 1'b1, 32'h0, 7'h00},
    '{`FCS_OPC_SIGNFLAGS, 32'hFFFFFFFF, 32'h0, 2'h2, 1'b0, 32'h0, 7'h00},
    '{`FCS_OPC_SIGN, 32'h40400000, 32'h0, 2'h0, 1'b1, 32'h1, 7'h00},
    '{`FCS_OPC_SIGN, 32'hBF800000, 32'h0, 2'h3, 1'b1, 32'hFFFFFFFF, 7'h00},
    '{`FCS_OPC_SIGN, 32'h80800000, 32'h0, 2'h0, 1'b1, 32'hFFFFFFFF, 7'h00},
    '{`FCS_OPC_SIGN, 32'h00000000, 32'h0, 2'h0, 1'b1, 32'h0, 7'h00},
    '{`FCS_OPC_SIGN, 32'hFFFFFFFF, 32'h0, 2'h2, 1'b0, 32'h0, 7'h00},
    '{`FCS_OPC_SIGN, 32'h80400000, 32'h0, 2'h0, 1'b1, 32'h0, 7'h20},
    '{`FCS_OPC_SIGN, 32'hFFFFFFFF, 32'h0, 2'h3, 1'b1, 32'h0, 7'h30},
    '{`FCS_OPC_SIGNFLAGS, 32'h80400000, 32'h0, 2'h0, 1'b1, 32'h20, 7'h30}
  };
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  logic        issue_valid = 1'b0;
  logic [7:0]  issue_opcode = 8'h00;
  logic [2:0]  issue_slot = 3'h0;
  logic [6:0]  issue_dest = 7'h00;
  logic [31:0] src_a = 32'h0;
  logic [31:0] src_b = 32'h0;
  logic        guard_present = 1'b0;
  logic [31:0] guard_value = 32'h0;
  logic        status_wr_en = 1'b0;
  logic [6:0]  status_wr_flags = 7'h00;
  logic [6:0]  other_unit_flags = 7'h00;
  logic        dest_wr_en;
  logic [6:0]  dest_index;
  logic [31:0] dest_data;
  logic        slot_error;
  logic [6:0]  program_status_word;
  int          num_errors = 0;
  int          checks = 0;

  always #25 clock = ~clock;

  fcs_unit dut_u (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .issue_valid(issue_valid),
    .issue_opcode(issue_opcode), .issue_slot(issue_slot), .issue_dest(issue_dest),
    .first_source_register(src_a), .second_source_register(src_b),
    .guard_present(guard_present), .guard_value(guard_value), .status_wr_en(status_wr_en),
    .status_wr_flags(status_wr_flags), .other_unit_flags(other_unit_flags),
    .dest_wr_en(dest_wr_en), .dest_index(dest_index), .dest_data(dest_data),
    .slot_error(slot_error), .program_status_word(program_status_word));

  fcs_regfile_model rf_u (.clock(clock), .wr_en(dest_wr_en), .wr_index(dest_index),
    .wr_data(dest_data));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Holds the op for one edge, then looks after the answer edge
  task automatic issue(input logic [7:0] opc, input logic [31:0] a, input logic [31:0] b,
                       input logic [1:0] g, input logic [6:0] dst, input logic [2:0] slot,
                       input logic [6:0] oth);
    @(posedge clock);
    issue_valid <= 1'b1;
    issue_opcode <= opc;
    src_a <= a;
    src_b <= b;
    guard_present <= g[1];
    guard_value <= {31'h0, g[0]};
    issue_dest <= dst;
    issue_slot <= slot;
    other_unit_flags <= oth;
    @(posedge clock);
    issue_valid <= 1'b0;
    other_unit_flags <= 7'h00;
    @(negedge clock);
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #(2000 * 50);
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 18; i++)
    begin
      issue(rows[i].opc, rows[i].a, rows[i].b, rows[i].g, 7'(i + 1), `FCS_ISSUE_SLOT, 7'h00);
      chk("dest_wr_en", 32'(dest_wr_en), 32'(rows[i].wr));
      chk("dest_data", dest_data, rows[i].res);
      chk("psw", 32'(program_status_word), 32'(rows[i].psw));
      @(posedge clock);
      #1;
      if (rows[i].wr)
      begin
        chk("regfile", rf_u.regs[i + 1], rows[i].res);
        chk("dest_index", 32'(dest_index), 32'(i + 1));
      end
    end
    issue(`FCS_OPC_SIGN, 32'hBF800000, 32'h0, 2'h0, 7'h11, `FCS_ISSUE_SLOT, 7'h08);
    chk("psw or", 32'(program_status_word), 32'h38);
    issue(`FCS_OPC_SIGN, 32'h80400000, 32'h0, 2'h0, 7'h12, 3'h2, 7'h00);
    chk("slot_error", 32'(slot_error), 32'h1);
    chk("slot wr", 32'(dest_wr_en), 32'h0);
    chk("slot psw", 32'(program_status_word), 32'h38);
    @(posedge clock);
    status_wr_en <= 1'b1;
    status_wr_flags <= 7'h00;
    @(posedge clock);
    status_wr_en <= 1'b0;
    @(negedge clock);
    chk("psw clear", 32'(program_status_word), 32'h0);
    issue(`FCS_OPC_SIGN, 32'hBF800000, 32'h0, 2'h0, 7'h13, `FCS_ISSUE_SLOT, 7'h40);
    chk("psw pre reset", 32'(program_status_word), 32'h40);
    @(posedge clock);
    rst_b <= 1'b0;
    #5;
    chk("reset psw", 32'(program_status_word), 32'h0);
    chk("reset data", dest_data, 32'h0);
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    issue(`FCS_OPC_SIGN, 32'h80400000, 32'h0, 2'h0, 7'h14, `FCS_ISSUE_SLOT, 7'h00);
    chk("psw after reset", 32'(program_status_word), 32'h20);
    // Status write and a flag set in one cycle: the set must survive
    fork
      issue(`FCS_OPC_SIGN, 32'hFFFFFFFF, 32'h0, 2'h0, 7'h15, `FCS_ISSUE_SLOT, 7'h00);
      begin
        @(posedge clock);
        status_wr_en <= 1'b1;
        status_wr_flags <= 7'h01;
        @(posedge clock);
        status_wr_en <= 1'b0;
      end
    join
    chk("psw write and set", 32'(program_status_word), 32'h11);
    chk("nan sign data", dest_data, 32'h0);
    @(posedge clock);
    clk_en <= 1'b0;
    issue(`FCS_OPC_SIGN, 32'hBF800000, 32'h0, 2'h0, 7'h16, `FCS_ISSUE_SLOT, 7'h40);
    chk("frozen wr", 32'(dest_wr_en), 32'h0);
    chk("frozen data", dest_data, 32'h0);
    chk("frozen psw", 32'(program_status_word), 32'h11);
    @(posedge clock);
    clk_en <= 1'b1;
    report_and_stop();
  end
endmodule
